// ### rtl/bbc_map.svh
// Register offsets, field positions and reset values of the battery bank.
`ifndef BBC_MAP_SVH
`define BBC_MAP_SVH
`define BBC_OFS_COUNTER 8'h20
`define BBC_OFS_UPPER 8'h24
`define BBC_OFS_FEATURE 8'h28
`define BBC_OFS_DEBOUNCE 8'h34
`define BBC_FEATURE_MSB 7
`define BBC_DEBOUNCE_BIT 0
`define BBC_RST_COUNTER 32'h0000_0000
`define BBC_RST_UPPER 32'h0000_0000
`define BBC_RST_FEATURE 8'h00
`define BBC_RST_DEBOUNCE 1'b0
`endif

// ### rtl/bbc_pkg.sv
// Types shared by the battery-backed register bank.
package bbc_pkg;
   typedef struct packed {
      logic [31:0] counter;
      logic [31:0] upper;
      logic [7:0] feature;
      logic debounce;
   } bbc_regs_t;
endpackage : bbc_pkg

// ### rtl/bbc_regs.sv
// Battery-backed register bank with a read-advancing counter.
`timescale 1ns/100ps
`include "bbc_map.svh"
module bbc_regs (
   // Clock, battery-domain reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register interface.
   input wire logic [7:0] addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [31:0] wr_data,
   output logic [31:0] rd_data,
   // Controls driven by the bank.
   output logic debounce_en,
   output logic [7:0] boot_feature
);
   bbc_pkg::bbc_regs_t regs;
   bbc_pkg::bbc_regs_t next_regs;
   logic [31:0] next_rd_data;
   logic rd_take;
   logic wr_take;

   // Every decode in the logic goes through here; the first checks below compare addr directly.
   function automatic logic bbc_hit(input logic [7:0] a,
      input logic [7:0] ofs);
      return a == ofs;
   endfunction : bbc_hit

   // Offsets outside this set read as zero and swallow writes.
   function automatic logic bbc_mapped(input logic [7:0] a);
      return bbc_hit(a, `BBC_OFS_COUNTER) || bbc_hit(a, `BBC_OFS_UPPER)
         || bbc_hit(a, `BBC_OFS_FEATURE) || bbc_hit(a, `BBC_OFS_DEBOUNCE);
   endfunction : bbc_mapped

   // A strobe only counts while the enable is high.
   assign rd_take = ce && rd_en;
   assign wr_take = ce && wr_en;

   // The counter only moves on reads, so a write at its offset is a no-op.
   always_comb begin
      next_regs = regs;
      next_rd_data = rd_data;
      if (rd_en) begin
         if (bbc_hit(addr, `BBC_OFS_COUNTER)) begin
            next_rd_data = regs.counter;
            next_regs.counter = regs.counter + 32'h0000_0001;
         end else if (bbc_hit(addr, `BBC_OFS_UPPER)) begin
            next_rd_data = regs.upper;
         end else if (bbc_hit(addr, `BBC_OFS_FEATURE)) begin
            next_rd_data = {24'h00_0000, regs.feature};
         end else if (bbc_hit(addr, `BBC_OFS_DEBOUNCE)) begin
            next_rd_data = {31'h0000_0000, regs.debounce};
         end else begin
            next_rd_data = 32'h0000_0000;
         end
      end
      if (wr_en) begin
         if (bbc_hit(addr, `BBC_OFS_UPPER)) begin
            next_regs.upper = wr_data;
         end else if (bbc_hit(addr, `BBC_OFS_FEATURE)) begin
            next_regs.feature = wr_data[`BBC_FEATURE_MSB:0];
         end else if (bbc_hit(addr, `BBC_OFS_DEBOUNCE)) begin
            next_regs.debounce = wr_data[`BBC_DEBOUNCE_BIT];
         end
      end
   end

   // The rst input must be the battery-domain reset only.
   always_ff @(posedge clk) begin
      if (rst) begin
         regs.counter <= `BBC_RST_COUNTER;
         regs.upper <= `BBC_RST_UPPER;
         regs.feature <= `BBC_RST_FEATURE;
         regs.debounce <= `BBC_RST_DEBOUNCE;
         rd_data <= 32'h0000_0000;
         debounce_en <= 1'b0;
         boot_feature <= 8'h00;
      end else if (ce) begin
         regs <= next_regs;
         rd_data <= next_rd_data;
         debounce_en <= next_regs.debounce;
         boot_feature <= next_regs.feature;
      end
   end

   property p_count_read;
      @(posedge clk) disable iff (rst)
         (ce && rd_en && addr == `BBC_OFS_COUNTER)
         |=> (regs.counter == $past(regs.counter) + 32'h0000_0001)
         && (rd_data == $past(regs.counter));
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("counter did not advance on read");

   property p_count_hold;
      @(posedge clk) disable iff (rst)
         !(ce && rd_en && addr == `BBC_OFS_COUNTER) |=> $stable(regs.counter);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("counter moved without a read");

   property p_reset_zero;
      @(posedge clk) rst |=> regs.counter == 32'h0000_0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("counter not cleared by reset");

   property p_upper_wr;
      @(posedge clk) disable iff (rst)
         (ce && wr_en && addr == `BBC_OFS_UPPER)
         |=> regs.upper == $past(wr_data);
   endproperty
   a_upper_wr: assert property (p_upper_wr)
      else $error("upper word write lost");

   property p_feat_wr;
      @(posedge clk) disable iff (rst)
         (ce && wr_en && addr == `BBC_OFS_FEATURE)
         |=> boot_feature == $past(wr_data[7:0]);
   endproperty
   a_feat_wr: assert property (p_feat_wr)
      else $error("feature byte write lost");

   property p_deb_wr;
      @(posedge clk) disable iff (rst)
         (ce && wr_en && addr == `BBC_OFS_DEBOUNCE)
         |=> debounce_en == $past(wr_data[0]);
   endproperty
   a_deb_wr: assert property (p_deb_wr)
      else $error("debounce enable write lost");

   property p_resv_feat;
      @(posedge clk) disable iff (rst)
         (ce && rd_en && addr == `BBC_OFS_FEATURE) |=> rd_data[31:8] == 24'h0;
   endproperty
   a_resv_feat: assert property (p_resv_feat)
      else $error("reserved feature bits not zero");

   property p_resv_deb;
      @(posedge clk) disable iff (rst)
         (ce && rd_en && addr == `BBC_OFS_DEBOUNCE) |=> rd_data[31:1] == 31'h0;
   endproperty
   a_resv_deb: assert property (p_resv_deb)
      else $error("reserved debounce bits not zero");

   property p_ctr_wr;
      @(posedge clk) disable iff (rst)
         (wr_take && !rd_en && bbc_hit(addr, `BBC_OFS_COUNTER))
         |=> regs.counter == $past(regs.counter);
   endproperty
   a_ctr_wr: assert property (p_ctr_wr)
      else $error("write changed the counter");

   property p_rd_hold;
      @(posedge clk) disable iff (rst)
         !rd_take |=> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");

   property p_upper_rd;
      @(posedge clk) disable iff (rst)
         (rd_take && bbc_hit(addr, `BBC_OFS_UPPER))
         |=> rd_data == $past(regs.upper);
   endproperty
   a_upper_rd: assert property (p_upper_rd)
      else $error("upper word read wrong");

   property p_upper_hold;
      @(posedge clk) disable iff (rst)
         !(wr_take && bbc_hit(addr, `BBC_OFS_UPPER))
         |=> $stable(regs.upper);
   endproperty
   a_upper_hold: assert property (p_upper_hold)
      else $error("upper word moved without a write");

   property p_rst_upper;
      @(posedge clk) rst |=> regs.upper == `BBC_RST_UPPER;
   endproperty
   a_rst_upper: assert property (p_rst_upper)
      else $error("upper word not cleared by reset");

   property p_feat_rd;
      @(posedge clk) disable iff (rst)
         (rd_take && bbc_hit(addr, `BBC_OFS_FEATURE))
         |=> rd_data[7:0] == $past(regs.feature);
   endproperty
   a_feat_rd: assert property (p_feat_rd)
      else $error("feature byte read wrong");

   property p_feat_hold;
      @(posedge clk) disable iff (rst)
         !(wr_take && bbc_hit(addr, `BBC_OFS_FEATURE))
         |=> $stable(boot_feature);
   endproperty
   a_feat_hold: assert property (p_feat_hold)
      else $error("feature byte moved without a write");

   property p_rst_feat;
      @(posedge clk) rst
         |=> boot_feature == `BBC_RST_FEATURE
         && regs.feature == `BBC_RST_FEATURE;
   endproperty
   a_rst_feat: assert property (p_rst_feat)
      else $error("feature byte not cleared by reset");

   property p_deb_hold;
      @(posedge clk) disable iff (rst)
         !(wr_take && bbc_hit(addr, `BBC_OFS_DEBOUNCE))
         |=> $stable(debounce_en);
   endproperty
   a_deb_hold: assert property (p_deb_hold)
      else $error("debounce enable moved without a write");

   property p_rst_deb;
      @(posedge clk) rst
         |=> debounce_en == `BBC_RST_DEBOUNCE
         && regs.debounce == `BBC_RST_DEBOUNCE;
   endproperty
   a_rst_deb: assert property (p_rst_deb)
      else $error("debounce enable not cleared by reset");

   property p_unmapped_rd;
      @(posedge clk) disable iff (rst)
         (rd_take && !bbc_mapped(addr)) |=> rd_data == 32'h0000_0000;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd)
      else $error("unmapped offset did not read zero");
endmodule : bbc_regs

// ### sim/bbc_regs_tb.sv
// Self-checking testbench for the battery-backed register bank.
`timescale 1ns/100ps
module bbc_regs_tb;
   logic clk, rst, ce, rd_en, wr_en, debounce_en;
   logic [7:0] addr, boot_feature;
   logic [31:0] wr_data, rd_data;
   int err_total, total_checks;
   bbc_regs dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .rd_en(rd_en),
      .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
      .debounce_en(debounce_en), .boot_feature(boot_feature));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Each strobe is set once per cycle so back-to-back accesses stay clean.
   task cyc(input logic r, input logic w, input logic [7:0] a,
      input logic [31:0] d);
      rd_en = r;
      wr_en = w;
      addr = a;
      wr_data = d;
      @(posedge clk);
      #1;
   endtask : cyc
   task do_reset;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      #1 rst = 1'b0;
   endtask : do_reset
   task t_count;
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      chk(rd_data, 32'h0);
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      chk(rd_data, 32'h1);
      cyc(1'b0, 1'b1, 8'h20, 32'hffff_ffff);
      cyc(1'b1, 1'b1, 8'h20, 32'h1234_5678);
      chk(rd_data, 32'h2);
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      chk(rd_data, 32'h3);
   endtask : t_count
   // Software view: a stored epoch in the upper word, the counter below it.
   task t_wide;
      logic [63:0] wide;
      cyc(1'b0, 1'b1, 8'h24, 32'h0000_0011);
      cyc(1'b1, 1'b1, 8'h24, 32'h0000_0022);
      chk(rd_data, 32'h0000_0011);
      cyc(1'b1, 1'b0, 8'h24, 32'h0);
      wide[63:32] = rd_data;
      ce = 1'b0;
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      ce = 1'b1;
      chk(rd_data, 32'h0000_0022);
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      wide[31:0] = rd_data;
      chk(wide[63:32], 32'h0000_0022);
      chk(wide[31:0], 32'h0000_0004);
   endtask : t_wide
   task t_regs;
      cyc(1'b0, 1'b1, 8'h24, 32'ha5a5_5a5a);
      cyc(1'b1, 1'b0, 8'h24, 32'h0);
      chk(rd_data, 32'ha5a5_5a5a);
      cyc(1'b0, 1'b1, 8'h28, 32'hffff_ffc3);
      cyc(1'b1, 1'b0, 8'h28, 32'h0);
      chk(rd_data, 32'h0000_00c3);
      chk({24'h0, boot_feature}, 32'hc3);
      cyc(1'b0, 1'b1, 8'h34, 32'hffff_ffff);
      cyc(1'b1, 1'b0, 8'h34, 32'h0);
      chk(rd_data, 32'h1);
      chk({31'h0, debounce_en}, 32'h1);
      ce = 1'b0;
      cyc(1'b0, 1'b1, 8'h34, 32'h0);
      ce = 1'b1;
      chk({31'h0, debounce_en}, 32'h1);
      cyc(1'b1, 1'b0, 8'h2c, 32'h0);
      chk(rd_data, 32'h0);
   endtask : t_regs
   // A second battery reset must clear everything it owns.
   task t_rereset;
      cyc(1'b0, 1'b0, 8'h0, 32'h0);
      do_reset();
      chk({23'h0, debounce_en, boot_feature}, 32'h0);
      cyc(1'b1, 1'b0, 8'h20, 32'h0);
      chk(rd_data, 32'h0);
      cyc(1'b1, 1'b0, 8'h24, 32'h0);
      chk(rd_data, 32'h0);
      cyc(1'b0, 1'b0, 8'h0, 32'h0);
   endtask : t_rereset
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   initial begin
      {rd_en, wr_en, addr, wr_data} = '0;
      err_total = 0;
      total_checks = 0;
      ce = 1'b1;
      do_reset();
      chk({rd_data[22:0], debounce_en, boot_feature}, 32'h0);
      t_count();
      t_wide();
      t_regs();
      t_rereset();
      complete_run();
   end
endmodule : bbc_regs_tb
